//--- src/key_scan_pkg.sv
// Constants and types shared by the key matrix scanner
package key_scan_pkg;
  localparam int SCAN_LINES = 8;
  localparam int KEY_LINES = 4;
  localparam int SEG_COUNT = 71;
  localparam int CLK_HZ = 10000000;
  // Low period of one scan pulse and gap between pulses, in ns
  localparam int SCAN_LOW_NS = 1600;
  localparam int SCAN_HIGH_NS = 400;
  localparam int SCAN_LOW_CYC = (SCAN_LOW_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int SCAN_HIGH_CYC = (SCAN_HIGH_NS * (CLK_HZ / 1000000) + 999) / 1000;
  // Sample point at three quarters of the low period
  localparam int SAMPLE_CYC = (SCAN_LOW_CYC * 3) / 4;
  // Delay from end of scan cycle to key register load
  localparam int LOAD_DELAY_CYC = 2;
  // Request drops this many clocks before the next scan cycle
  localparam int REQ_LEAD_CYC = 2;
  localparam logic [7:0] KEY_STATUS_RESET = 8'h00;
  localparam int KEY_LINE_LSB = 4;
  localparam int KEY_RSVD_BIT = 3;
  localparam int SCAN_IDX_LSB = 0;
  localparam logic [1:0] SEG_NONSELECT = 2'h1;

  typedef struct packed {
    logic [3:0] key_line_bits;
    logic reserved_zero;
    logic [2:0] scan_index_bits;
  } key_status_t;
endpackage

//--- src/scan_pulse_gen.sv
// Scan line pulse timer: low period, gap and sample strobe
`timescale 1ns/1ps
`default_nettype none
module scan_pulse_gen #(
  parameter int LOW_CYC = key_scan_pkg::SCAN_LOW_CYC,
  parameter int HIGH_CYC = key_scan_pkg::SCAN_HIGH_CYC,
  parameter int SAMPLE_AT = key_scan_pkg::SAMPLE_CYC
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic run_in,
  output logic low_out,
  output logic sample_out,
  output logic done_out
);
  localparam int PERIOD = LOW_CYC + HIGH_CYC;
  logic [7:0] count;

  // Counts one pulse period while running
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      count <= 8'h00;
    end else if (!run_in || count == 8'(PERIOD - 1)) begin
      count <= 8'h00;
    end else begin
      count <= count + 8'h01;
    end
  end

  assign low_out = run_in && (count < 8'(LOW_CYC));
  assign sample_out = run_in && (count == 8'(SAMPLE_AT));
  assign done_out = run_in && (count == 8'(PERIOD - 1));
endmodule
`default_nettype wire

//--- src/key_matrix_scanner.sv
// Key matrix scanner: scan lines, key sampling, key register and request
// What this block does
// - Scan eight lines by four inputs, 32 keys
// - Raise key request when key pressed
// - Drop request two clocks before next scan
// - Key register zero when no key
// - Freeze key register while host reads
// - Load key data two clocks after scan
// - Scan lines shared with first eight segments
// - Pull-ups on, other segments non-select during window
// - Host instruction switches scanning on/off
// - Scan off: no detect, no pull-ups, all non-select
// - Sample inputs at three quarters of low
// - Key byte: lines 7-4, zero, index 2-0
// - Pressed key sets its line bit, index
// - Same-line roll-over shows several line bits
`timescale 1ns/1ps
`default_nettype none
module key_matrix_scanner #(
  parameter int SCAN_N = key_scan_pkg::SCAN_LINES,
  parameter int KEY_N = key_scan_pkg::KEY_LINES
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic scan_window_in,
  input wire logic scan_enable_in,
  input wire logic key_read_busy_in,
  input wire logic [KEY_N-1:0] key_in,
  input wire logic [SCAN_N-1:0] segment_data_in,
  output logic [SCAN_N-1:0] scan_line_out,
  output logic scan_drive_out,
  output logic seg_nonselect_low_out,
  output logic seg_nonselect_all_out,
  output logic [1:0] seg_nonselect_level_out,
  output logic key_pullup_out,
  output logic key_request_out,
  output var key_scan_pkg::key_status_t key_status_out
);
  typedef enum logic [1:0] {
    IDLE = 2'b00,
    SCAN = 2'b01,
    LOAD = 2'b11,
    HOLD = 2'b10
  } scan_state_t;

  scan_state_t state;
  logic [2:0] line_idx;
  logic pulse_low, pulse_sample, pulse_done;
  logic [1:0] load_count;
  logic [1:0] window_dly;
  key_scan_pkg::key_status_t capture;
  logic found;
  logic scan_on;

  assign scan_on = scan_window_in && scan_enable_in;

  scan_pulse_gen u_pulse (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .run_in(state == SCAN),
    .low_out(pulse_low),
    .sample_out(pulse_sample),
    .done_out(pulse_done)
  );

  // Scan sequence: walk lines 0..7, then wait to load, then hold
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state <= IDLE;
      line_idx <= 3'h0;
      load_count <= 2'h0;
    end else begin
      unique case (state)
        IDLE: begin
          line_idx <= 3'h0;
          // Hold off the scan until the request has been low for two clocks
          if (scan_on && window_dly[1]) begin
            state <= SCAN;
          end
        end
        SCAN: begin
          if (!scan_on) begin
            state <= IDLE;
          end else if (pulse_done) begin
            if (line_idx == 3'(SCAN_N - 1)) begin
              state <= LOAD;
              load_count <= 2'h0;
            end else begin
              line_idx <= line_idx + 3'h1;
            end
          end
        end
        LOAD: begin
          load_count <= load_count + 2'h1;
          if (load_count == 2'(key_scan_pkg::LOAD_DELAY_CYC - 1)) begin
            state <= HOLD;
          end
        end
        HOLD: begin
          if (!scan_window_in) begin
            state <= IDLE;
          end
        end
      endcase
    end
  end

  // Capture pressed keys; first scan line with a press wins the index
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      capture <= key_scan_pkg::KEY_STATUS_RESET;
      found <= 1'b0;
    end else if (state == IDLE) begin
      capture <= key_scan_pkg::KEY_STATUS_RESET;
      found <= 1'b0;
    end else if (state == SCAN && pulse_sample && !found && key_in != '1) begin
      capture.key_line_bits <= ~key_in;
      capture.reserved_zero <= 1'b0;
      capture.scan_index_bits <= line_idx;
      found <= 1'b1;
    end
  end

  // Key register update, frozen while the host reads it
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      key_status_out <= key_scan_pkg::KEY_STATUS_RESET;
    end else if (state == LOAD && load_count == 2'(key_scan_pkg::LOAD_DELAY_CYC - 1)
                 && !key_read_busy_in) begin
      key_status_out <= capture;
    end
  end

  // Request rises with a press, drops when a new window opens
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      key_request_out <= 1'b0;
      window_dly <= 2'h0;
    end else begin
      window_dly <= {window_dly[0], scan_window_in};
      if (scan_window_in && !window_dly[0]) begin
        key_request_out <= 1'b0;
      end else if (state == LOAD && load_count == 2'(key_scan_pkg::LOAD_DELAY_CYC - 1)
                   && found) begin
        key_request_out <= 1'b1;
      end
    end
  end

  // Shared scan/segment lines and window pin controls
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      scan_line_out <= '1;
      scan_drive_out <= 1'b0;
      key_pullup_out <= 1'b0;
      seg_nonselect_low_out <= 1'b0;
      seg_nonselect_all_out <= 1'b0;
      seg_nonselect_level_out <= key_scan_pkg::SEG_NONSELECT;
    end else begin
      scan_drive_out <= scan_on;
      key_pullup_out <= scan_on;
      seg_nonselect_low_out <= scan_window_in;
      seg_nonselect_all_out <= scan_window_in && !scan_enable_in;
      seg_nonselect_level_out <= key_scan_pkg::SEG_NONSELECT;
      for (int i = 0; i < SCAN_N; i++) begin
        if (!scan_window_in) begin
          scan_line_out[i] <= segment_data_in[i];
        end else begin
          scan_line_out[i] <= !(state == SCAN && pulse_low && line_idx == 3'(i));
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- verif/key_scan_assertions.sv
// Port checker for the key matrix scanner
`timescale 1ns/1ps
`default_nettype none
module key_scan_chk #(
  parameter int SCAN_N = 8,
  parameter int KEY_N = 4
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic scan_window_in,
  input wire logic scan_enable_in,
  input wire logic key_read_busy_in,
  input wire logic [SCAN_N-1:0] scan_line_out,
  input wire logic scan_drive_out,
  input wire logic seg_nonselect_all_out,
  input wire logic key_pullup_out,
  input wire logic key_request_out,
  input wire key_scan_pkg::key_status_t key_status_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  // First scan pulse stays low sixteen cycles, then returns high
  sequence line0_low;
    !scan_line_out[0] [*8] ##1 !scan_line_out[0] [*8] ##1 scan_line_out[0];
  endsequence
  // Timing, format and window relations
  chk_pulse_len: assert property ($fell(scan_line_out[0]) && scan_drive_out |-> line0_low)
    else $error("scan pulse length wrong");
  chk_one_low: assert property (scan_drive_out |-> $countones(~scan_line_out) <= 1)
    else $error("more than one scan line low");
  chk_rsvd_zero: assert property (key_status_out.reserved_zero == 1'b0)
    else $error("reserved key bit set");
  chk_req_cause: assert property (key_request_out |-> key_status_out != 8'h00)
    else $error("request without key data");
  chk_req_drop: assert property ($rose(scan_window_in) |-> ##2 !key_request_out)
    else $error("request not dropped before scan");
  chk_busy_hold: assert property (key_read_busy_in |=> $stable(key_status_out))
    else $error("key register changed while busy");
  chk_pullup_on: assert property (1 |=> key_pullup_out == $past(scan_window_in && scan_enable_in))
    else $error("pull-up enable wrong");
  chk_off_nonsel: assert property (1 |=> seg_nonselect_all_out == $past(scan_window_in && !scan_enable_in))
    else $error("all-segment non-select wrong");
endmodule
`default_nettype wire

//--- verif/key_matrix_model.sv
// Key switch matrix of four inputs by eight scan lines
`timescale 1ns/1ps
`default_nettype none
module key_matrix_model (
  input wire logic [31:0] pressed_in,
  input wire logic [7:0] scan_line_in,
  input wire logic pullup_in,
  output logic [3:0] key_out
);
  // Closed switch pulls its input low while its line is low; unpulled inputs float low
  always_comb begin
    key_out = 4'hF;
    for (int i = 0; i < 32; i++) begin
      if (pressed_in[i] && !scan_line_in[i / 4]) key_out[i % 4] = 1'b0;
    end
    if (!pullup_in) key_out = 4'h0;
  end
endmodule
`default_nettype wire

//--- verif/tb_top.sv
// Self-checking bench for the key matrix scanner
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic win = 1'b0;
  logic en = 1'b1;
  logic busy = 1'b0;
  logic [31:0] pressed = 32'h0;
  logic [3:0] keys;
  logic [7:0] lines;
  logic pull, req;
  logic nsl, nsa;
  key_scan_pkg::key_status_t status;
  int miscompares = 0;
  int cmp_count = 0;
  int cycles = 0;
  // Pressed switches beside the expected key byte
  logic [39:0] rows [5] = '{40'h00000000_00, 40'h00000400_42, 40'h00900000_95,
    40'h80000000_87, 40'h00000001_10};
  always #50 clk_in = ~clk_in;
  key_matrix_scanner DUT (.clk_in(clk_in), .rst_b_in(rst_b_in), .scan_window_in(win),
    .scan_enable_in(en), .key_read_busy_in(busy), .key_in(keys), .segment_data_in(8'hFF),
    .scan_line_out(lines), .scan_drive_out(), .seg_nonselect_low_out(nsl),
    .seg_nonselect_all_out(nsa), .seg_nonselect_level_out(), .key_pullup_out(pull),
    .key_request_out(req), .key_status_out(status));
  key_matrix_model keypad (.pressed_in(pressed), .scan_line_in(lines), .pullup_in(pull),
    .key_out(keys));
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One window long enough for a full scan and the register load
  task automatic scan(input logic [31:0] m);
    @(negedge clk_in);
    pressed = m;
    win = 1'b1;
    repeat (3) @(negedge clk_in);
    check({7'h00, req}, 8'h00);
    check({7'h00, pull}, {7'h00, en});
    check({7'h00, nsl}, 8'h01);
    check({7'h00, nsa}, {7'h00, ~en});
    repeat (170) @(negedge clk_in);
    win = 1'b0;
  endtask
  // Cut a hang short
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      end_of_test();
    end
  end
  initial begin
    repeat (6) @(negedge clk_in);
    rst_b_in = 1'b1;
    check(status, 8'h00);
    check(lines, 8'hFF);
    foreach (rows[i]) begin
      scan(rows[i][39:8]);
      check(status, rows[i][7:0]);
      check({7'h00, req}, {7'h00, |rows[i][7:0]});
    end
    busy = 1'b1;
    scan(32'h00000400);
    check(status, 8'h10);
    busy = 1'b0;
    en = 1'b0;
    scan(32'h00000400);
    check({7'h00, req}, 8'h00);
    en = 1'b1;
    rst_b_in = 1'b0;
    @(negedge clk_in);
    check(status, 8'h00);
    end_of_test();
  end
endmodule
bind key_matrix_scanner key_scan_chk #(.SCAN_N(SCAN_N), .KEY_N(KEY_N)) u_chk (.clk_in,
  .rst_b_in, .scan_window_in, .scan_enable_in, .key_read_busy_in, .scan_line_out,
  .scan_drive_out, .seg_nonselect_all_out, .key_pullup_out, .key_request_out,
  .key_status_out);
`default_nettype wire
